// *** hw/lcs_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing figures of the
 * laser current compensation and safety block.
 * Assumes a 50 MHz system clock and byte addresses on a 32-bit bus.
 */
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH

// Byte offsets
`define LCS_A_CTRL0   8'h00
`define LCS_A_CTRL1   8'h04
`define LCS_A_BIASSET 8'h08
`define LCS_A_MODSET  8'h0C
`define LCS_A_GAIN    8'h10
`define LCS_A_BREF    8'h14
`define LCS_A_TSTART  8'h18
`define LCS_A_TEXP    8'h1C
`define LCS_A_FWCOEF  8'h20
`define LCS_A_STATUS  8'h24
`define LCS_A_DIAG    8'h28
`define LCS_A_MTXPWR  8'h2C
`define LCS_A_MBIAS   8'h30
`define LCS_A_MMOD    8'h34
`define LCS_A_MODDAC  8'h38

// Control register 0 fields
`define LCS_C0_CLPWR  0
`define LCS_C0_BCOMP  1
`define LCS_C0_TCOMP  2
`define LCS_C0_TSEL   3
`define LCS_C0_FWTEMP 4
`define LCS_C0_SWDIS  5
`define LCS_C0_BYPASS 6
`define LCS_C0_RESET  7'h04

// Control register 1 fields
`define LCS_C1_FRESET 0
`define LCS_C1_OVRD   1

// Exponent limits and arithmetic
`define LCS_EXP_MIN   5'sh14
`define LCS_EXP_MAX   5'sh0B
`define LCS_GAIN_FRAC 7
`define LCS_DAC_MAX   12'hFFF
`define LCS_SETTLE_TOL 13'h0040

// Timing
`define LCS_CLK_MHZ    50
`define LCS_SETTLE_US  3000
`define LCS_SAMPLE_DIV 256

`endif

// *** hw/lcs_pkg.sv ***
/*
 * Types of the laser current compensation and safety block.
 * Assumes lcs_regs.svh is not needed here; widths are fixed by the ADCs.
 */
package lcs_pkg;

	// Safety sequence states, one-hot
	typedef enum logic [4:0] {
		LCS_INIT   = 5'b00001,
		LCS_OFF    = 5'b00010,
		LCS_CHECK  = 5'b00100,
		LCS_SETTLE = 5'b01000,
		LCS_RUN    = 5'b10000
	} lcs_fsm_t;

	// Monitor converter words as they arrive
	typedef struct packed {
		logic [11:0] txpwr;
		logic [11:0] bias;
		logic [11:0] modu;
		logic [11:0] int_temp;
		logic [11:0] aux2;
	} lcs_adc_t;

	// Whole state of the block
	typedef struct packed {
		logic [6:0]  ctrl0;
		logic        latch_override;
		logic [11:0] bias_setpoint;
		logic [11:0] modulation_setpoint;
		logic [7:0]  comp_gain;
		logic [11:0] bias_monitor_reference;
		logic [11:0] temp_start;
		logic [4:0]  temp_first_order_exponent;
		logic [15:0] fw_temp_coef;
		logic [5:0]  cmp_s1;
		logic [5:0]  cmp_s2;
		lcs_adc_t    adc_s1;
		lcs_adc_t    adc_s2;
		lcs_adc_t    adc;
		logic        dis_prev;
		lcs_fsm_t    fsm;
		logic        init_done;
		logic [17:0] timer;
		logic [15:0] div;
		logic        fault_latched;
		logic [6:0]  diag;
		logic [11:0] bias_dac;
		logic [11:0] mod_dac;
		logic        bias_en;
		logic        mod_en;
		logic        supply_on;
		logic        fault;
		logic        ack;
		logic [31:0] rdata;
	} lcs_state_t;

endpackage : lcs_pkg

// *** hw/lcs_top.sv ***
/*
 * Laser current compensation and safety controller with a Wishbone slave.
 * Assumes classic Wishbone on clk_i, comparator levels and converter words
 * arriving asynchronously, and the analogue DACs and supply switch outside.
 */
// Function
// - Open loop: bias DAC follows bias setpoint
// - Modulation setpoint is the compensation base
// - Bias compensation samples bias monitor periodically
// - Mod DAC = setpoint + gain*(monitor - reference)
// - Temperature compensation resets on and wins
// - Select internal or second aux temperature
// - Exponent accepts -12 through +11
// - Mod DAC = setpoint + (start-temp)*2^exponent
// - Start threshold in 12-bit temperature units
// - Firmware enable uses firmware coefficient term
// - Tx power, bias, modulation monitors readable
// - Any comparator fault kills currents, raises fault
// - Fault sets matching diagnostic status bit
// - Fault stays latched until disable toggles
// - Supply switch opens on disable, or on fault without bypass
// - Either disable turns both currents off
// - Start only when unbypassed monitors healthy
// - Disable falling edge triggers pin short check
// - Pass starts 3 ms bias settle timer
// - Bypass keeps modulation on, still latches
// - Bypass plus fault reset clears latch
// - Latch override: fault output follows live fault
`timescale 1ns/1ps
`include "lcs_regs.svh"

module lcs_top
	import lcs_pkg::*;
#(
	parameter int SETTLE_CYCLES = `LCS_SETTLE_US * `LCS_CLK_MHZ,
	parameter int SAMPLE_DIV    = `LCS_SAMPLE_DIV
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Pins and comparators
	input  wire logic        laser_disable_in_i,
	input  wire logic [4:0]  fault_cmp_i,
	input  wire lcs_adc_t    adc_i,
	// Laser drive
	output logic      [11:0] bias_dac_o,
	output logic      [11:0] modulation_dac_value_o,
	output logic             bias_en_o,
	output logic             mod_en_o,
	output logic             switched_laser_supply_o,
	output logic             fault_o
);

	lcs_state_t s;
	lcs_state_t next_s;

	// Merge byte lanes 0 and 1 into a register of up to 16 bits
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = d[7:0];
		end
		if (sel[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction : merge

	// Next-state logic for bus, safety sequence and compensation
	always_comb begin
		logic        wr;
		logic        rd_hit;
		logic        dis;
		logic        live;
		logic        fall;
		logic        set_f;
		logic        clr_f;
		logic        tick;
		logic        settled;
		logic        tcomp;
		logic [15:0] m;
		logic [11:0] temp;
		logic signed [12:0] d13;
		logic signed [12:0] bdiff;
		logic signed [4:0]  ex;
		logic signed [24:0] term;
		logic signed [21:0] prod;
		logic signed [25:0] sum;
		logic [6:0]  dset;
		wr = 1'b0;
		rd_hit = 1'b0;
		dis = 1'b0;
		live = 1'b0;
		fall = 1'b0;
		set_f = 1'b0;
		clr_f = 1'b0;
		tick = 1'b0;
		settled = 1'b0;
		tcomp = 1'b0;
		m = 16'h0000;
		temp = 12'h000;
		d13 = 13'sh0000;
		bdiff = 13'sh0000;
		ex = 5'sh00;
		term = 25'sh0000000;
		prod = 22'sh000000;
		sum = 26'sh0000000;
		dset = 7'h00;
		next_s = s;

		// Two-stage synchronisers; stage one feeds stage two only
		// Converter words are taken as slow; a torn word spoils one sample only
		next_s.cmp_s1 = {laser_disable_in_i, fault_cmp_i};
		next_s.cmp_s2 = s.cmp_s1;
		next_s.adc_s1 = adc_i;
		next_s.adc_s2 = s.adc_s1;

		// Either disable source counts; a floating pin reads high outside
		dis = s.cmp_s2[5] | s.ctrl0[`LCS_C0_SWDIS];
		next_s.dis_prev = dis;
		fall = s.dis_prev & ~dis;
		live = |s.cmp_s2[4:0];

		// Sample divider paces monitor capture and compensation
		// Mod DAC moves only on ticks, so the drive steps at a steady pace
		tick = (s.div == 16'h0000);
		next_s.div = tick ? 16'(SAMPLE_DIV - 1) : s.div - 16'h0001;
		if (tick) begin
			next_s.adc = s.adc_s2;
		end

		// Wishbone: answer one cycle after the strobe, then drop
		// A write lands on the edge that raises ack; unmapped reads return zero
		next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
		wr = next_s.ack & wb_we_i;
		next_s.rdata = 32'h0000_0000;
		if (next_s.ack & ~wb_we_i) begin
			rd_hit = 1'b1;
			case ({wb_adr_i[7:2], 2'b00})
				`LCS_A_CTRL0:   next_s.rdata = {25'h0, s.ctrl0};
				`LCS_A_CTRL1:   next_s.rdata = {30'h0, s.latch_override, 1'b0};
				`LCS_A_BIASSET: next_s.rdata = {20'h0, s.bias_setpoint};
				`LCS_A_MODSET:  next_s.rdata = {20'h0, s.modulation_setpoint};
				`LCS_A_GAIN:    next_s.rdata = {24'h0, s.comp_gain};
				`LCS_A_BREF:    next_s.rdata = {20'h0, s.bias_monitor_reference};
				`LCS_A_TSTART:  next_s.rdata = {20'h0, s.temp_start};
				`LCS_A_TEXP:    next_s.rdata = {27'h0, s.temp_first_order_exponent};
				`LCS_A_FWCOEF:  next_s.rdata = {16'h0, s.fw_temp_coef};
				`LCS_A_STATUS:  next_s.rdata = {18'h0, s.fsm, s.init_done,
					s.fault_latched, 1'b0, s.cmp_s2};        // Bit 6 spare
				`LCS_A_DIAG:    next_s.rdata = {25'h0, s.diag};
				`LCS_A_MTXPWR:  next_s.rdata = {20'h0, s.adc.txpwr};
				`LCS_A_MBIAS:   next_s.rdata = {20'h0, s.adc.bias};
				`LCS_A_MMOD:    next_s.rdata = {20'h0, s.adc.modu};
				`LCS_A_MODDAC:  next_s.rdata = {20'h0, s.mod_dac};
				default:        rd_hit = 1'b0;
			endcase
		end
		// Unmapped writes are dropped but still acknowledged
		if (wr) begin
			case ({wb_adr_i[7:2], 2'b00})
				`LCS_A_CTRL0: begin
					m = merge({9'h0, s.ctrl0}, wb_dat_i, wb_sel_i);
					next_s.ctrl0 = m[6:0];
				end
				`LCS_A_CTRL1: begin
					if (wb_sel_i[0]) begin
						next_s.latch_override = wb_dat_i[`LCS_C1_OVRD];
						// Override is a level; fault reset is a strobe that reads back 0
						// Fault reset only acts while bypass is on
						clr_f = wb_dat_i[`LCS_C1_FRESET]
							& s.ctrl0[`LCS_C0_BYPASS];
					end
				end
				`LCS_A_BIASSET: begin
					m = merge({4'h0, s.bias_setpoint}, wb_dat_i, wb_sel_i);
					next_s.bias_setpoint = m[11:0];
				end
				`LCS_A_MODSET: begin
					m = merge({4'h0, s.modulation_setpoint}, wb_dat_i, wb_sel_i);
					next_s.modulation_setpoint = m[11:0];
				end
				`LCS_A_GAIN: begin
					m = merge({8'h0, s.comp_gain}, wb_dat_i, wb_sel_i);
					next_s.comp_gain = m[7:0];
				end
				`LCS_A_BREF: begin
					m = merge({4'h0, s.bias_monitor_reference}, wb_dat_i, wb_sel_i);
					next_s.bias_monitor_reference = m[11:0];
				end
				`LCS_A_TSTART: begin
					m = merge({4'h0, s.temp_start}, wb_dat_i, wb_sel_i);
					next_s.temp_start = m[11:0];
				end
				`LCS_A_TEXP: begin
					// Out-of-range exponents clamp to the nearest limit
					if (wb_sel_i[0]) begin
						ex = $signed(wb_dat_i[4:0]);
						if (ex < $signed(`LCS_EXP_MIN)) begin
							ex = `LCS_EXP_MIN;
						end else if (ex > $signed(`LCS_EXP_MAX)) begin
							ex = `LCS_EXP_MAX;
						end
						next_s.temp_first_order_exponent = ex;
					end
				end
				`LCS_A_FWCOEF: begin
					// Signed term, applied without scaling
					next_s.fw_temp_coef = merge(s.fw_temp_coef, wb_dat_i, wb_sel_i);
				end
				default: begin
				end
			endcase
		end

		// Safety sequence
		// Settle test reads the synced monitor, not the tick-paced copy, to react early
		settled = 1'b0;
		bdiff = $signed({1'b0, s.adc_s2.bias}) - $signed({1'b0, s.bias_setpoint});
		if (bdiff < 0) begin
			bdiff = -bdiff;
		end
		settled = (bdiff <= $signed(`LCS_SETTLE_TOL));
		// Comparators before start-up do not latch, so power-up glitches are ignored
		dset = {1'b0, 1'b0, s.init_done ? s.cmp_s2[4:0] : 5'h00};
		case (s.fsm)
			LCS_INIT: begin
				// Start only with every watched comparator healthy, or at once under bypass
				if (~live | s.ctrl0[`LCS_C0_BYPASS]) begin
					next_s.init_done = 1'b1;
					next_s.fsm = LCS_OFF;
				end
			end
			LCS_OFF: begin
				// Wait until both disable sources are low
				if (~dis) begin
					next_s.fsm = LCS_CHECK;
				end
			end
			LCS_CHECK: begin
				// Pin short check after enable; pass arms the one-shot
				if (live) begin
					dset[5] = 1'b1;
					next_s.fsm = LCS_RUN;
				end else begin
					next_s.timer = 18'(SETTLE_CYCLES - 1);
					next_s.fsm = LCS_SETTLE;
				end
			end
			LCS_SETTLE: begin
				// Bias must reach the setpoint window before the one-shot runs out
				if (settled) begin
					next_s.fsm = LCS_RUN;
				end else if (s.timer == 18'h00000) begin
					dset[6] = 1'b1;
					next_s.fsm = LCS_RUN;
				end else begin
					next_s.timer = s.timer - 18'h00001;
				end
			end
			LCS_RUN: begin
				// Faults act through the latch below, not through this sequence
			end
			default: next_s.fsm = LCS_INIT;
		endcase
		// Any disable sends the sequence back, so the next enable re-checks the pins
		if (dis & s.init_done) begin
			next_s.fsm = LCS_OFF;
		end

		// Fault latch: a new fault wins over any clear in the same cycle
		// A clear also wipes the diagnostic bits of the faults it releases
		set_f = |dset;
		clr_f = clr_f | fall;
		if (set_f) begin
			next_s.fault_latched = 1'b1;
			next_s.diag = (clr_f ? 7'h00 : s.diag) | dset;
		end else if (clr_f) begin
			next_s.fault_latched = 1'b0;
			next_s.diag = 7'h00;
		end

		// Fault output: latched, or live with override set
		next_s.fault = s.latch_override ? (|dset) : next_s.fault_latched;

		// Current enables; bypass keeps the laser running through a fault
		// Currents run from the start of settling, since settling needs bias current
		// Under bypass the supply stays closed too, or the laser would go dark anyway
		next_s.mod_en = ~dis & s.fsm[3] | ~dis & s.fsm[4];
		next_s.mod_en = next_s.mod_en
			& (~next_s.fault_latched | s.ctrl0[`LCS_C0_BYPASS]);
		next_s.bias_en = next_s.mod_en;
		next_s.supply_on = next_s.mod_en;

		// Open loop bias drive; closed loop leaves the value frozen
		if (~s.ctrl0[`LCS_C0_CLPWR]) begin
			next_s.bias_dac = s.bias_setpoint;
		end

		// Modulation compensation term
		// Temperature wins over the bias term whenever it is enabled
		temp = s.ctrl0[`LCS_C0_TSEL] ? s.adc.aux2 : s.adc.int_temp;
		tcomp = s.ctrl0[`LCS_C0_TCOMP];
		ex = $signed(s.temp_first_order_exponent);
		d13 = $signed({1'b0, s.temp_start}) - $signed({1'b0, temp});
		if (tcomp & s.ctrl0[`LCS_C0_FWTEMP]) begin
			term = 25'($signed(s.fw_temp_coef));
		end else if (tcomp) begin
			// Negative exponents shift right, keeping the sign of the difference
			if (ex[4]) begin
				term = 25'(d13) >>> 4'(-ex);
			end else begin
				term = 25'(d13) <<< ex[3:0];
			end
		end else if (s.ctrl0[`LCS_C0_BCOMP]) begin
			// Gain carries seven fraction bits
			bdiff = $signed({1'b0, s.adc.bias})
				- $signed({1'b0, s.bias_monitor_reference});
			prod = $signed({1'b0, s.comp_gain}) * bdiff;
			term = 25'(prod >>> `LCS_GAIN_FRAC);
		end
		sum = $signed({14'h0000, s.modulation_setpoint}) + 26'(term);
		if (tick) begin
			// Saturate so a large correction cannot wrap the DAC code
			if (sum < 0) begin
				next_s.mod_dac = 12'h000;
			end else if (sum > $signed({14'h0000, `LCS_DAC_MAX})) begin
				next_s.mod_dac = `LCS_DAC_MAX;
			end else begin
				next_s.mod_dac = sum[11:0];
			end
		end
	end

	// State register; a disabled safe state out of reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.ctrl0 <= `LCS_C0_RESET;
			s.fsm <= LCS_INIT;
			// Disable path resets to the disabled level, as a floating pin reads
			s.dis_prev <= 1'b1;
			s.cmp_s1 <= 6'h20;
			s.cmp_s2 <= 6'h20;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign wb_dat_o               = s.rdata;
	assign wb_ack_o               = s.ack;
	assign bias_dac_o             = s.bias_dac;
	assign modulation_dac_value_o = s.mod_dac;
	assign bias_en_o              = s.bias_en;
	assign mod_en_o               = s.mod_en;
	assign switched_laser_supply_o = s.supply_on;
	assign fault_o                = s.fault;

endmodule : lcs_top

// *** tb/lcs_top_sva.sv ***
/* Port checker for the laser current safety block.
   Assumes binding to lcs_top, one clock, synchronous reset. */
`timescale 1ns/1ps
module lcs_top_sva (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Safety pins and drive
	input wire logic        laser_disable_in_i,
	input wire logic [4:0]  fault_cmp_i,
	input wire logic        bias_en_o,
	input wire logic        mod_en_o,
	input wire logic        switched_laser_supply_o,
	input wire logic        fault_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers once, one cycle after a fresh request
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than a cycle");
	property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
	// Disable pin passes two sync stages, so allow margin
	property p_dis_off; laser_disable_in_i [*5] |-> !bias_en_o && !mod_en_o; endproperty
	a_dis_off: assert property (p_dis_off) else $error("current on while disabled");
	property p_dis_sup; laser_disable_in_i [*5] |-> !switched_laser_supply_o; endproperty
	a_dis_sup: assert property (p_dis_sup) else $error("supply on while disabled");
	property p_flt; $rose(|fault_cmp_i) && bias_en_o |-> ##[1:5] fault_o; endproperty
	a_flt: assert property (p_flt) else $error("fault not reported");
	property p_en_late; $rose(bias_en_o) |-> !$past(laser_disable_in_i, 3); endproperty
	a_en_late: assert property (p_en_late) else $error("enable before check");
	property p_rst; $fell(rst_i) |-> !fault_o && !bias_en_o && !switched_laser_supply_o;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs live after reset");
	// Main scenarios seen
	c_en: cover property ($rose(bias_en_o));
	c_flt: cover property ($rose(fault_o));
	c_ack: cover property (wb_ack_o && wb_cyc_i);
endmodule : lcs_top_sva

bind lcs_top lcs_top_sva lcs_top_sva_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_dat_o, .wb_ack_o, .laser_disable_in_i, .fault_cmp_i, .bias_en_o, .mod_en_o,
	.switched_laser_supply_o, .fault_o);

// *** tb/lcs_far_model.sv ***
/* Host and laser model on the far side of the safety block.
   Assumes the bench sets host disable, pin shorts and temperatures. */
`timescale 1ns/1ps
module lcs_far_model
	import lcs_pkg::*;
(
	// Bench controls
	input  wire logic        clk_i,
	input  wire logic        host_dis_i,
	input  wire logic [4:0]  short_i,
	input  wire logic [11:0] temp_i,
	input  wire logic [11:0] aux_i,
	// Drive from the design
	input  wire logic [11:0] bias_dac_i,
	input  wire logic        bias_en_i,
	input  wire logic [11:0] mod_dac_i,
	input  wire logic        mod_en_i,
	// Pins into the design
	output logic             laser_disable_in_o,
	output logic [4:0]       fault_cmp_o,
	output lcs_adc_t         adc_o
);
	// Host holds the line high unless it asks for light
	assign laser_disable_in_o = host_dis_i;
	assign fault_cmp_o = short_i;
	// Laser currents read back one clock late, zero when switched off
	always_ff @(posedge clk_i) begin
		adc_o.bias <= bias_en_i ? bias_dac_i : 12'h000;
		adc_o.txpwr <= bias_en_i ? {1'b0, bias_dac_i[11:1]} : 12'h000;
		adc_o.modu <= mod_en_i ? mod_dac_i : 12'h000;
		adc_o.int_temp <= temp_i;
		adc_o.aux2 <= aux_i;
	end
endmodule : lcs_far_model

// *** tb/lcs_top_tb.sv ***
/* Self-checking bench of the laser current safety block.
   Assumes short settle and sample counts set by parameter. */
`timescale 1ns/1ps
`include "lcs_regs.svh"
module lcs_top_tb
	import lcs_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic        host_dis = 1'b1;
	logic [4:0]  short = 5'h00;
	wire  [31:0] rdat;
	wire         ack;
	wire         dis;
	wire  [4:0]  cmp;
	wire  lcs_adc_t adc;
	wire  [11:0] bdac;
	wire  [11:0] mdac;
	wire         ben;
	wire         men;
	wire         sup;
	wire         flt;
	int          err_total = 0;
	int          cmp_count = 0;
	logic [31:0] q;
	// Address, write value, expected readback
	logic [39:0] rows [10] = '{{8'h08, 16'h0123, 16'h0123}, {8'h0C, 16'h0200, 16'h0200},
		{8'h10, 16'h0080, 16'h0080}, {8'h14, 16'h0100, 16'h0100},
		{8'h18, 16'h0400, 16'h0400}, {8'h20, 16'h0030, 16'h0030},
		{8'h1C, 16'h0010, 16'h0014}, {8'h1C, 16'h000C, 16'h000B},
		{8'h3C, 16'h0FFF, 16'h0000}, {8'h1C, 16'h0000, 16'h0000}};

	always #10 clk_i = ~clk_i;

	lcs_top #(.SETTLE_CYCLES(50), .SAMPLE_DIV(4)) lcs_top_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .laser_disable_in_i(dis),
		.fault_cmp_i(cmp), .adc_i(adc), .bias_dac_o(bdac), .modulation_dac_value_o(mdac),
		.bias_en_o(ben), .mod_en_o(men), .switched_laser_supply_o(sup), .fault_o(flt));
	lcs_far_model lcs_far_model_inst (.clk_i(clk_i), .host_dis_i(host_dis), .short_i(short),
		.temp_i(12'h3F0), .aux_i(12'h3E0), .bias_dac_i(bdac), .bias_en_i(ben),
		.mod_dac_i(mdac), .mod_en_i(men), .laser_disable_in_o(dis), .fault_cmp_o(cmp),
		.adc_o(adc));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One classic cycle; held until ack is sampled high
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd

	task pause(input int n);
		repeat (n) @(posedge clk_i);
	endtask : pause

	task wait_on();
		while (ben !== 1'b1)
			@(posedge clk_i);
	endtask : wait_on

	function logic [31:0] flg();
		return {28'h0, flt, ben, men, sup};
	endfunction : flg

	task finish_test();
		$display("Comparisons %0d, errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	// Cuts a hang short
	initial begin
		#200000;
		err_total++;
		finish_test();
	end

	// Register table, then bring-up, compensation and safety cases
	initial begin
		pause(4);
		rst_i <= 1'b0;
		pause(1);
		chk(flg(), 32'h0);
		rd(`LCS_A_CTRL0, 32'h04);
		foreach (rows[i]) begin
			bus(1'b1, rows[i][39:32], {16'h0, rows[i][31:16]});
			rd(rows[i][39:32], {16'h0, rows[i][15:0]});
		end
		host_dis <= 1'b0;
		wait_on();
		pause(40);
		chk(flg(), 32'h7);
		chk({20'h0, mdac}, 32'h210);
		chk({20'h0, bdac}, 32'h123);
		bus(1'b1, `LCS_A_TEXP, 32'h2);
		pause(40);
		chk({20'h0, mdac}, 32'h240);
		bus(1'b1, `LCS_A_CTRL0, 32'h0C);
		pause(40);
		chk({20'h0, mdac}, 32'h280);
		bus(1'b1, `LCS_A_CTRL0, 32'h14);
		pause(40);
		chk({20'h0, mdac}, 32'h230);
		bus(1'b1, `LCS_A_CTRL0, 32'h02);
		pause(40);
		chk({20'h0, mdac}, 32'h223);
		rd(`LCS_A_MBIAS, 32'h123);
		rd(`LCS_A_MTXPWR, 32'h091);
		rd(`LCS_A_MMOD, 32'h223);
		// Latched fault, cleared only by a disable toggle
		short <= 5'h02;
		pause(6);
		chk(flg(), 32'h8);
		rd(`LCS_A_DIAG, 32'h02);
		short <= 5'h00;
		pause(6);
		chk(flg(), 32'h8);
		host_dis <= 1'b1;
		pause(6);
		host_dis <= 1'b0;
		wait_on();
		pause(2);
		chk(flg(), 32'h7);
		bus(1'b1, `LCS_A_CTRL0, 32'h22);
		pause(5);
		chk(flg(), 32'h0);
		// Frozen bias drive cannot settle, so the one-shot runs out
		bus(1'b1, `LCS_A_CTRL0, 32'h23);
		bus(1'b1, `LCS_A_BIASSET, 32'h323);
		bus(1'b1, `LCS_A_CTRL0, 32'h03);
		pause(80);
		chk(flg(), 32'h8);
		chk({20'h0, bdac}, 32'h123);
		rd(`LCS_A_DIAG, 32'h40);
		// A short present when the disable drops fails the pin check
		bus(1'b1, `LCS_A_CTRL0, 32'h22);
		short <= 5'h04;
		pause(6);
		bus(1'b1, `LCS_A_CTRL0, 32'h02);
		pause(4);
		chk(flg(), 32'h8);
		rd(`LCS_A_DIAG, 32'h24);
		short <= 5'h00;
		pause(4);
		bus(1'b1, `LCS_A_CTRL0, 32'h22);
		bus(1'b1, `LCS_A_CTRL0, 32'h42);
		wait_on();
		pause(2);
		// Bypass keeps light on; reset bit clears the latch
		short <= 5'h01;
		pause(6);
		chk(flg(), 32'hF);
		short <= 5'h00;
		pause(4);
		bus(1'b1, `LCS_A_CTRL1, 32'h1);
		pause(3);
		chk(flg(), 32'h7);
		bus(1'b1, `LCS_A_CTRL1, 32'h2);
		short <= 5'h08;
		pause(6);
		chk(flg(), 32'hF);
		short <= 5'h00;
		pause(6);
		chk(flg(), 32'h7);
		// Mid-run reset restores the safe outputs and the reset defaults
		rst_i <= 1'b1;
		pause(2);
		rst_i <= 1'b0;
		pause(1);
		chk(flg(), 32'h0);
		rd(`LCS_A_CTRL0, 32'h04);
		rd(`LCS_A_CTRL1, 32'h00);
		finish_test();
	end
endmodule : lcs_top_tb
